// ===== design/olsd_cfg.svh
// Offsets, field positions, reset values and timing counts of the driver block
// Operation
// R1 - Serial frames count only while device select is held low.
// R2 - While selected, shift serial input in on each falling serial clock edge.
// R3 - Device select rising edge copies the shift register into the output latches.
// R4 - Copy only after a whole multiple of 8 clocks; else keep old latches.
// R5 - Master changes device select only while serial clock is low.
// R6 - Outputs 1,2 on when direct input low or control bit high.
// R7 - Outputs 3 to 8 follow only their own latched control bit.
// R8 - Direct inputs default high, so an open input leaves output off.
// R9 - Internal reset is external reset OR undervoltage; clears all eight latches.
// R10 - Outputs 1 to 6: overcurrent sets overload latch, output off at once.
// R11 - Outputs 7,8: overlimit only regulates; overtemperature latches and switches off.
// R12 - Outputs 1,2 status is filtered into fault latches cleared while selected.
// R13 - Latched status of outputs 1,2 may be stale; read twice.
// R14 - Outputs 1,2 status high when off-above or on-below threshold.
// R15 - Outputs 3 to 8 status goes unlatched into the status word.
// R16 - Outputs 3 to 6 overcurrent and any off-below case report low; code reports an overcurrent-off output high if above threshold.
// R17 - Outputs 7,8 on with voltage above threshold report low.
// R18 - Device select falling edge loads eight status bits into the shift register.
// R19 - While selected, next shift register bit drives serial output each rising clock.
// R20 - Serial output floats after device select returns high.
// R21 - Outputs 1,2 faults must persist 15 to 50 us before latching.
// R22 - Word bit i maps to output i+1, most significant bit shifted first.
// R23 - Internal reset clears control and overload latches; all outputs off.
`ifndef OLSD_CFG_SVH
`define OLSD_CFG_SVH

`define OLSD_CTRL_OFS   32'h0000_0000
`define OLSD_STATE_OFS  32'h0000_0004
`define OLSD_DIAG_OFS   32'h0000_0008
`define OLSD_CTRL_HOLD  0
`define OLSD_RESP_OKAY  2'h0
`define OLSD_RESP_SLV   2'h2
`define OLSD_PIN_INIT   6'h17
`define OLSD_WORD_BITS  8
`define OLSD_CLK_NS     10
`define OLSD_FILT_NS    15000
`define OLSD_FILT_CYC   ((`OLSD_FILT_NS + `OLSD_CLK_NS - 1) / `OLSD_CLK_NS)

`endif

// ===== design/olsd_pkg.sv
// Types shared by the driver block and its bench
package olsd_pkg;

    typedef struct packed {
        logic [5:0] overcurrent;
        logic [1:0] overlimit;
        logic [1:0] overtemp;
        logic [7:0] above_thr;
    } olsd_diag_type;

    typedef struct packed {
        logic        awvalid;
        logic [31:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic        rready;
    } olsd_axi_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } olsd_axi_rsp_type;

endpackage : olsd_pkg

// ===== design/olsd_top.sv
// Serial control, protection latches and diagnostics of the octal driver
`timescale 1ns/1ps
`include "olsd_cfg.svh"

module olsd_sync #(
    parameter int         W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_ff <= INIT;
            q_ff    <= INIT;
        end
        else
        begin
            meta_ff <= d_i;
            q_ff    <= meta_ff;
        end
    end

    assign q_o = q_ff;
endmodule : olsd_sync

module olsd_top (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       sclk_i,
    input  wire logic                       device_select_n_i,
    input  wire logic                       sdi_i,
    input  wire logic                       direct_drive_in_1_n_i,
    input  wire logic                       direct_drive_in_2_n_i,
    input  wire logic                       external_reset_n_i,
    input  wire logic                       uv_reset_i,
    input  wire olsd_pkg::olsd_diag_type    diag_i,
    input  wire olsd_pkg::olsd_axi_req_type axi_i,
    output olsd_pkg::olsd_axi_rsp_type      axi_o,
    output logic [7:0]                      out_on_o,
    output logic [1:0]                      regulate_o,
    output logic                            sdo_o,
    output logic                            sdo_oe_n_o
);
    import olsd_pkg::*;

    logic [5:0]    pin_s;
    olsd_diag_type diag_s;
    logic          uv_s;
    logic          sclk_s;
    logic          sel_n_s;
    logic          sdi_s;
    logic          dd1_n_s;
    logic          dd2_n_s;
    logic          ext_n_s;

    // Pull-up default: direct inputs start high so outputs stay off
    olsd_sync #(.W(6), .INIT(`OLSD_PIN_INIT)) u_pin_sync ( // R8
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({sclk_i, device_select_n_i, sdi_i,
                 direct_drive_in_2_n_i, direct_drive_in_1_n_i, external_reset_n_i}),
        .q_o   (pin_s)
    );

    olsd_sync #(.W($bits(olsd_diag_type) + 1)) u_diag_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({uv_reset_i, diag_i}),
        .q_o   ({uv_s, diag_s})
    );

    assign {sclk_s, sel_n_s, sdi_s, dd2_n_s, dd1_n_s, ext_n_s} = pin_s;

    logic        ctrl_hold_ff;
    logic        int_rst;
    logic        sclk_d_ff;
    logic        sel_d_ff;
    logic        sel_fall;
    logic        sel_rise;
    logic        sck_fall;
    logic        sck_rise;
    logic [7:0]  sr_ff;
    logic [2:0]  cnt_ff;
    logic        any_ff;
    logic        frame_ok;
    logic [7:0]  ctl_ff;
    logic [7:0]  ovl_ff;
    logic [7:0]  nxt_ovl;
    logic [7:0]  ovl_hit;
    logic [7:0]  on_cmd;
    logic [7:0]  out_on_ff;
    logic [1:0]  reg_ff;
    logic [7:0]  stat_raw;
    logic [7:0]  stat_word;
    logic [1:0]  fault_ff;
    logic [1:0]  flt_hit;
    logic [10:0] flt_cnt_ff [2];
    logic        sdo_ff;
    logic        oe_n_ff;

    assign int_rst = rst_i | ~ext_n_s | uv_s | ctrl_hold_ff; // R9

    // Select only moves while the serial clock is low, so edges never coincide
    assign sel_fall = sel_d_ff & ~sel_n_s; // R5
    assign sel_rise = ~sel_d_ff & sel_n_s;
    assign sck_fall = sclk_d_ff & ~sclk_s & ~sel_n_s; // R1
    assign sck_rise = ~sclk_d_ff & sclk_s & ~sel_n_s; // R1
    assign frame_ok = any_ff & (cnt_ff == 3'h0); // R4

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sclk_d_ff <= 1'b0;
            sel_d_ff  <= 1'b1;
        end
        else
        begin
            sclk_d_ff <= sclk_s;
            sel_d_ff  <= sel_n_s;
        end
    end

    // Bit i is output i+1; most significant bit travels first
    always_ff @(posedge clk_i)
    begin
        if (int_rst)
            sr_ff <= 8'h00;
        else if (sel_fall)
            sr_ff <= stat_word; // R18
        else if (sck_fall)
            sr_ff <= {sr_ff[6:0], sdi_s}; // R2 R22
    end

    // A three-bit count wraps, so any nonzero multiple of eight clocks is accepted
    always_ff @(posedge clk_i)
    begin
        if (int_rst || sel_fall)
        begin
            cnt_ff <= 3'h0;
            any_ff <= 1'b0;
        end
        else if (sck_fall)
        begin
            cnt_ff <= cnt_ff + 3'h1; // R4
            any_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (int_rst)
            ctl_ff <= 8'h00; // R23
        else if (sel_rise && frame_ok)
            ctl_ff <= sr_ff; // R3
    end

    assign on_cmd[0]   = ctl_ff[0] | ~dd1_n_s; // R6
    assign on_cmd[1]   = ctl_ff[1] | ~dd2_n_s; // R6
    assign on_cmd[7:2] = ctl_ff[7:2]; // R7

    // Outside internal reset, overload clears only on a fresh accepted word; a new hit still wins
    assign ovl_hit = {diag_s.overtemp & out_on_ff[7:6], // R11
                      diag_s.overcurrent & out_on_ff[5:0]}; // R10
    assign nxt_ovl = ovl_hit | (ovl_ff & ~{8{sel_rise & frame_ok}});

    always_ff @(posedge clk_i)
    begin
        if (int_rst)
        begin
            ovl_ff    <= 8'h00; // R23
            out_on_ff <= 8'h00;
            reg_ff    <= 2'h0;
        end
        else
        begin
            ovl_ff    <= nxt_ovl;
            out_on_ff <= on_cmd & ~nxt_ovl; // R10 R11
            reg_ff    <= out_on_ff[7:6] & diag_s.overlimit; // R11
        end
    end

    // High means healthy: off-above or on-below threshold
    assign stat_raw  = out_on_ff ^ diag_s.above_thr; // R14 R16 R17
    // Latched bits lag one frame after a fault goes away
    assign stat_word = {stat_raw[7:2], ~fault_ff}; // R15 R13
    assign flt_hit[0] = ~stat_raw[0] && (flt_cnt_ff[0] == 11'(`OLSD_FILT_CYC));
    assign flt_hit[1] = ~stat_raw[1] && (flt_cnt_ff[1] == 11'(`OLSD_FILT_CYC));

    // Filter uses the shortest allowed time
    for (genvar i = 0; i < 2; i++)
    begin : g_filt
        always_ff @(posedge clk_i)
        begin
            if (int_rst || stat_raw[i])
                flt_cnt_ff[i] <= 11'h000;
            else if (!flt_hit[i])
                flt_cnt_ff[i] <= flt_cnt_ff[i] + 11'h001; // R21
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (int_rst)
            fault_ff <= 2'h0;
        else
            fault_ff <= flt_hit | (fault_ff & {2{sel_n_s}}); // R12
    end

    always_ff @(posedge clk_i)
    begin
        if (int_rst)
        begin
            sdo_ff  <= 1'b0;
            oe_n_ff <= 1'b1;
        end
        else
        begin
            oe_n_ff <= sel_n_s; // R20
            if (sel_fall)
                sdo_ff <= stat_word[7]; // R18
            else if (sck_rise)
                sdo_ff <= sr_ff[7]; // R19
        end
    end

    assign out_on_o   = out_on_ff;
    assign regulate_o = reg_ff;
    assign sdo_o      = sdo_ff;
    assign sdo_oe_n_o = oe_n_ff;

    logic        aw_got_ff;
    logic        w_got_ff;
    logic [31:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;
    logic        awready_ff;
    logic        wready_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        arready_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;
    logic        aw_hs;
    logic        w_hs;
    logic        ar_hs;
    logic        do_wr;
    logic        nxt_aw_got;
    logic        nxt_w_got;
    logic        nxt_bvalid;
    logic        nxt_rvalid;
    logic        wr_ctrl;
    logic        wr_known;
    logic        rd_known;
    logic [31:0] rd_word;

    assign aw_hs      = axi_i.awvalid & awready_ff;
    assign w_hs       = axi_i.wvalid & wready_ff;
    assign ar_hs      = axi_i.arvalid & arready_ff;
    assign do_wr      = aw_got_ff & w_got_ff & ~bvalid_ff;
    assign nxt_aw_got = aw_hs | (aw_got_ff & ~do_wr);
    assign nxt_w_got  = w_hs | (w_got_ff & ~do_wr);
    assign nxt_bvalid = do_wr | (bvalid_ff & ~axi_i.bready);
    assign nxt_rvalid = ar_hs | (rvalid_ff & ~axi_i.rready);
    assign wr_ctrl    = awaddr_ff == `OLSD_CTRL_OFS;
    assign wr_known   = wr_ctrl | (awaddr_ff == `OLSD_STATE_OFS)
                      | (awaddr_ff == `OLSD_DIAG_OFS);
    assign rd_known   = (axi_i.araddr == `OLSD_CTRL_OFS)
                      | (axi_i.araddr == `OLSD_STATE_OFS)
                      | (axi_i.araddr == `OLSD_DIAG_OFS);
    assign rd_word    = (axi_i.araddr == `OLSD_CTRL_OFS)  ? {31'h0, ctrl_hold_ff} :
                        (axi_i.araddr == `OLSD_STATE_OFS) ?
                            {6'h00, fault_ff, ctl_ff, ovl_ff, out_on_ff} :
                        (axi_i.araddr == `OLSD_DIAG_OFS)  ?
                            {14'h0000, reg_ff, sr_ff, stat_word} : 32'h0000_0000;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            aw_got_ff  <= 1'b0;
            w_got_ff   <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
        end
        else
        begin
            aw_got_ff  <= nxt_aw_got;
            w_got_ff   <= nxt_w_got;
            awready_ff <= ~nxt_aw_got & ~nxt_bvalid;
            wready_ff  <= ~nxt_w_got & ~nxt_bvalid;
            bvalid_ff  <= nxt_bvalid;
            arready_ff <= ~nxt_rvalid;
            rvalid_ff  <= nxt_rvalid;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            awaddr_ff <= 32'h0000_0000;
            wdata_ff  <= 32'h0000_0000;
            wstrb_ff  <= 4'h0;
            bresp_ff  <= 2'h0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= 2'h0;
        end
        else
        begin
            if (aw_hs)
                awaddr_ff <= axi_i.awaddr;
            if (w_hs)
            begin
                wdata_ff <= axi_i.wdata;
                wstrb_ff <= axi_i.wstrb;
            end
            if (do_wr)
                bresp_ff <= wr_known ? `OLSD_RESP_OKAY : `OLSD_RESP_SLV;
            if (ar_hs)
            begin
                rdata_ff <= rd_word;
                rresp_ff <= rd_known ? `OLSD_RESP_OKAY : `OLSD_RESP_SLV;
            end
        end
    end

    // Software hold acts like the external reset until cleared again
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctrl_hold_ff <= 1'b0;
        else if (do_wr && wr_ctrl && wstrb_ff[0])
            ctrl_hold_ff <= wdata_ff[`OLSD_CTRL_HOLD]; // R9
    end

    assign axi_o.awready = awready_ff;
    assign axi_o.wready  = wready_ff;
    assign axi_o.bvalid  = bvalid_ff;
    assign axi_o.bresp   = bresp_ff;
    assign axi_o.arready = arready_ff;
    assign axi_o.rvalid  = rvalid_ff;
    assign axi_o.rdata   = rdata_ff;
    assign axi_o.rresp   = rresp_ff;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (int_rst);

    frame_latch_a : assert property (sel_rise && frame_ok |=> ctl_ff == $past(sr_ff)) // R3
        else $error("accepted word not latched");
    frame_reject_a : assert property (sel_rise && !frame_ok |=> $stable(ctl_ff)) // R4
        else $error("short frame changed latches");
    shift_in_a : assert property (sck_fall |=> sr_ff == {$past(sr_ff[6:0]), $past(sdi_s)}) // R2
        else $error("serial bit not shifted in");
    idle_hold_a : assert property (sel_n_s && sel_d_ff |=> $stable(sr_ff)) // R1
        else $error("shift register moved while deselected");
    direct_on_a : assert property (!dd1_n_s && !nxt_ovl[0] |=> out_on_ff[0]) // R6
        else $error("output 1 not on from direct input");
    serial_only_a : assert property (##1 out_on_ff[7:2] == ($past(ctl_ff[7:2]) & ~ovl_ff[7:2])) // R7
        else $error("outputs 3 to 8 not following latch");
    overcurrent_cut_a : assert property (out_on_ff[0] && diag_s.overcurrent[0]
        |=> ovl_ff[0] && !out_on_ff[0]) // R10
        else $error("overcurrent did not switch output 1 off");
    thermal_cut_a : assert property (out_on_ff[7] && diag_s.overtemp[1]
        |=> ovl_ff[7] && !out_on_ff[7]) // R11
        else $error("overtemperature did not switch output 8 off");
    fault_clear_a : assert property (!sel_n_s && !flt_hit[0] |=> !fault_ff[0]) // R12
        else $error("fault latch not cleared while selected");
    fault_filter_a : assert property (!fault_ff[0] ##1 fault_ff[0]
        |-> $past(flt_cnt_ff[0]) == 11'(`OLSD_FILT_CYC)) // R21
        else $error("fault latched before filter time");
    sdo_float_a : assert property (sel_n_s |=> sdo_oe_n_o) // R20
        else $error("serial output driven while deselected");
    sdo_first_a : assert property (sel_fall |=> !sdo_oe_n_o && sdo_o == $past(stat_word[7])) // R18
        else $error("first status bit not presented");
    sdo_next_a : assert property (sck_rise && !sel_fall |=> sdo_o == $past(sr_ff[7])) // R19
        else $error("serial output not advanced");
    reset_clear_a : assert property (@(posedge clk_i) disable iff (rst_i)
        int_rst |=> ctl_ff == 8'h00 && ovl_ff == 8'h00 && out_on_ff == 8'h00) // R9 R23
        else $error("internal reset left latches set");

    frame_ok_c : cover property (sel_rise && frame_ok);
    frame_bad_c : cover property (sel_rise && any_ff && !frame_ok);
    fault_set_c : cover property (flt_hit[0]);
    overload_c : cover property (|ovl_hit);

endmodule : olsd_top

// ===== dv/olsd_spi_master.sv
// Serial master model that drives the link of the driver block
`timescale 1ns/1ps
module olsd_spi_master (
    input  wire logic clk_i,
    input  wire logic sdo_i,
    input  wire logic sdo_oe_n_i,
    output logic      sclk_o,
    output logic      device_select_n_o,
    output logic      sdi_o
);
    initial
    begin
        sclk_o            = 1'b0;
        device_select_n_o = 1'b1;
        sdi_o             = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wait_clk

    // Half period of 4 clk gives the 80 ns link period; sclk idles low between frames
    task automatic frame(input int nbits, input logic [15:0] data, input logic sel,
                         output logic [7:0] rd);
        rd = 8'h00;
        @(posedge clk_i);
        device_select_n_o <= ~sel;
        wait_clk(8);
        // Sample late in the high phase: the output bit advances three clocks after the rising edge
        for (int i = 0; i < nbits; i++)
        begin
            sclk_o <= 1'b1;
            sdi_o  <= data[nbits-1-i];
            wait_clk(4);
            if (i < 8)
                rd = {rd[6:0], sdo_oe_n_i ? 1'bx : sdo_i};
            sclk_o <= 1'b0;
            wait_clk(4);
        end
        device_select_n_o <= 1'b1;
        wait_clk(1);
        // A released line must not keep showing the last bit
        sdi_o <= ~sdi_o;
        wait_clk(8);
    endtask : frame
endmodule : olsd_spi_master

// ===== dv/test_olsd_top.sv
// Self-checking bench of the octal driver block: serial link and register bus
`timescale 1ns/1ps
`include "olsd_cfg.svh"
module test_olsd_top;
    import olsd_pkg::*;

    logic             clk_i      = 1'b0;
    logic             rst_i      = 1'b1;
    logic             direct_1_n;
    logic             direct_2_n;
    logic             ext_rst_n;
    logic             uv_rst;
    olsd_diag_type    diag;
    olsd_axi_req_type axi_req;
    olsd_axi_rsp_type axi_rsp;
    logic [7:0]       out_on;
    logic [1:0]       regulate;
    logic             sclk;
    logic             sel_n;
    logic             sdi;
    logic             sdo;
    logic             sdo_oe_n;
    logic [7:0]       st;
    int               err_count   = 0;
    int               comparisons = 0;
    int               cycles      = 0;
    int               cnt [4]     = '{7, 0, 9, 16};
    logic [7:0]       keep [4]    = '{8'ha5, 8'ha5, 8'ha5, 8'h3c};

    always #5 clk_i = ~clk_i;

    olsd_top dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .device_select_n_i(sel_n),
        .sdi_i(sdi), .direct_drive_in_1_n_i(direct_1_n), .direct_drive_in_2_n_i(direct_2_n),
        .external_reset_n_i(ext_rst_n), .uv_reset_i(uv_rst), .diag_i(diag),
        .axi_i(axi_req), .axi_o(axi_rsp), .out_on_o(out_on), .regulate_o(regulate),
        .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n)
    );

    olsd_spi_master spi_u (
        .clk_i(clk_i), .sdo_i(sdo), .sdo_oe_n_i(sdo_oe_n), .sclk_o(sclk),
        .device_select_n_o(sel_n), .sdi_o(sdi)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        if (err_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_count++;
            complete_run();
        end
    end

    task automatic wr_chk(input logic [31:0] addr, input logic [31:0] data,
                          input logic [1:0] exp_resp);
        logic aw_p;
        logic w_p;
        aw_p = 1'b1;
        w_p  = 1'b1;
        @(posedge clk_i);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr  <= addr;
        axi_req.wvalid  <= 1'b1;
        axi_req.wdata   <= data;
        axi_req.wstrb   <= 4'hf;
        axi_req.bready  <= 1'b1;
        while (aw_p || w_p)
        begin
            @(posedge clk_i);
            if (aw_p && axi_rsp.awready === 1'b1)
                axi_req.awvalid <= 1'b0;
            if (w_p && axi_rsp.wready === 1'b1)
                axi_req.wvalid <= 1'b0;
            aw_p = aw_p && axi_rsp.awready !== 1'b1;
            w_p  = w_p && axi_rsp.wready !== 1'b1;
        end
        while (axi_rsp.bvalid !== 1'b1)
            @(posedge clk_i);
        check(axi_rsp.bresp, exp_resp);
        axi_req.bready <= 1'b0;
    endtask : wr_chk

    task automatic rd_chk(input logic [31:0] addr, input logic [31:0] mask,
                          input logic [31:0] exp, input logic [1:0] exp_resp);
        @(posedge clk_i);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr  <= addr;
        axi_req.rready  <= 1'b1;
        do
            @(posedge clk_i);
        while (axi_rsp.arready !== 1'b1);
        axi_req.arvalid <= 1'b0;
        while (axi_rsp.rvalid !== 1'b1)
            @(posedge clk_i);
        check(axi_rsp.rdata & mask, exp);
        check(axi_rsp.rresp, exp_resp);
        axi_req.rready <= 1'b0;
    endtask : rd_chk

    initial
    begin
        direct_1_n <= 1'b1;
        direct_2_n <= 1'b1;
        ext_rst_n  <= 1'b1;
        uv_rst     <= 1'b0;
        diag       <= '{above_thr: 8'hff, default: '0};
        axi_req    <= '0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        spi_u.wait_clk(6);
        rd_chk(`OLSD_CTRL_OFS, 32'hffff_ffff, 32'h0, `OLSD_RESP_OKAY);
        rd_chk(`OLSD_STATE_OFS, 32'hffff_ffff, 32'h0, `OLSD_RESP_OKAY);
        rd_chk(`OLSD_DIAG_OFS, 32'hffff_ffff, 32'hff, `OLSD_RESP_OKAY);
        wr_chk(`OLSD_STATE_OFS, 32'hffff_ffff, `OLSD_RESP_OKAY);
        rd_chk(`OLSD_STATE_OFS, 32'hffff_ffff, 32'h0, `OLSD_RESP_OKAY);
        wr_chk(32'h0000_0010, 32'h1, `OLSD_RESP_SLV);
        rd_chk(32'h0000_0010, 32'hffff_ffff, 32'h0, `OLSD_RESP_SLV);
        // Control word, frame lengths and stray clocks while deselected
        spi_u.frame(8, 16'h00a5, 1'b1, st);
        check(out_on, 8'ha5);
        check(sdo_oe_n, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            spi_u.frame(cnt[i], 16'h5a3c, 1'b1, st);
            check(out_on, keep[i]);
        end
        spi_u.frame(8, 16'h00ff, 1'b0, st);
        check(out_on, 8'h3c);
        rd_chk(`OLSD_DIAG_OFS, 32'h0000_ff00, 32'h3c00, `OLSD_RESP_OKAY);
        // Direct inputs against control bits of outputs 1 and 2
        for (int c = 0; c < 2; c++)
        begin
            spi_u.frame(8, {14'h0, c[0], c[0]}, 1'b1, st);
            for (int i = 0; i < 4; i++)
            begin
                direct_1_n <= i[0];
                direct_2_n <= i[1];
                spi_u.wait_clk(8);
                check(out_on[1:0], 2'(~i[1:0] | {c[0], c[0]}));
            end
        end
        // Overcurrent on outputs 1 to 6 latches off, one after another
        spi_u.frame(8, 16'h00ff, 1'b1, st);
        for (int k = 0; k < 6; k++)
        begin
            diag.overcurrent[k] <= 1'b1;
            spi_u.wait_clk(8);
            diag.overcurrent[k] <= 1'b0;
            spi_u.wait_clk(8);
            check(out_on, 8'(~((8'h02 << k) - 8'h01)));
        end
        diag.overlimit <= 2'b11;
        spi_u.wait_clk(8);
        check(regulate, 2'b11);
        check(out_on[7:6], 2'b11);
        diag.overlimit <= 2'b00;
        diag.overtemp  <= 2'b10;
        spi_u.wait_clk(8);
        diag.overtemp <= 2'b00;
        spi_u.wait_clk(8);
        check(out_on[7:6], 2'b01);
        rd_chk(`OLSD_STATE_OFS, 32'h0000_ff00, 32'hbf00, `OLSD_RESP_OKAY);
        // Unlatched status of outputs 3 to 8, loaded at select fall
        spi_u.frame(8, 16'h00f0, 1'b1, st);
        diag.above_thr <= 8'hcf;
        spi_u.frame(8, 16'h00f0, 1'b1, st);
        check(st, 8'h3f);
        diag.above_thr <= 8'h33;
        spi_u.frame(8, 16'h00f0, 1'b1, st);
        check(st, 8'hc3);
        // Filtered fault latch of output 1
        spi_u.frame(8, 16'h0000, 1'b1, st);
        diag.above_thr <= 8'hfe;
        spi_u.wait_clk(1000);
        spi_u.frame(8, 16'h0000, 1'b1, st);
        check(st, 8'hff);
        spi_u.wait_clk(700);
        spi_u.frame(8, 16'h0000, 1'b1, st);
        check(st, 8'hfe);
        diag.above_thr <= 8'hff;
        spi_u.frame(8, 16'h0000, 1'b1, st);
        spi_u.frame(8, 16'h0000, 1'b1, st);
        check(st, 8'hff);
        // External, undervoltage and software hold resets each clear the latches
        for (int k = 0; k < 3; k++)
        begin
            spi_u.frame(8, 16'h00ff, 1'b1, st);
            ext_rst_n <= (k != 0);
            uv_rst    <= (k == 1);
            if (k == 2)
                wr_chk(`OLSD_CTRL_OFS, 32'h1, `OLSD_RESP_OKAY);
            spi_u.wait_clk(8);
            check(out_on, 8'h00);
            rd_chk(`OLSD_STATE_OFS, 32'h00ff_ffff, 32'h0, `OLSD_RESP_OKAY);
            ext_rst_n <= 1'b1;
            uv_rst    <= 1'b0;
            wr_chk(`OLSD_CTRL_OFS, 32'h0, `OLSD_RESP_OKAY);
            spi_u.wait_clk(8);
        end
        complete_run();
    end
endmodule : test_olsd_top
